// file: hdl/pbms_core.sv
// How it works
// RULE1 - Element active only if global protection enabled and unblocked; all conditions ANDed.
// RULE2 - Wide-frequency mode blocks fundamental elements off nominal frequency; RMS elements stay.
// RULE3 - Element with function disabled stays inactive regardless of blocking inputs.
// RULE4 - Permitted element is blocked while either assigned external block signal is high.
// RULE5 - Block-during-start input applies only to elements selected for it.
// RULE6 - Ground elements blocked by reverse interlock when permitted and signal high.
// RULE7 - Any settings write restarts protection, including the motor start logic.
// RULE8 - Restart forces motor state to stop even while running.
// RULE9 - After restart a running motor restarts stop-start-run without counting starts.
// RULE10 - Restart clears motor timer and pulses thermal model reset.
// RULE11 - Motor state has exactly four values: stop, start, run, trip.
// RULE12 - Normal sequence is stop to start, start to run, run to stop.
// RULE13 - Abnormal moves are start to stop, start to trip, run to trip.
// RULE14 - Any other protection trip in start or run forces trip.
// RULE15 - In trip, once currents have ceased, go to stop.
// RULE16 - Start declared when a phase current exceeds 30 percent of full load.
// RULE17 - Stop declared when all three phases are below stop threshold.
// RULE18 - Everything evaluated every clock; reset puts the machine in stop.
`timescale 1ns/10ps
`default_nettype none
module pbms_core import pbms_pkg::*; (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic NRST,
	// Register port
	input wire logic [AW-1:0] ADDR,
	input wire logic [DW-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [DW-1:0] RDATA,
	// Measurement and blocking sources
	input wire pbms_phase_t PHASE_I,
	input wire logic FREQ_IN_RANGE,
	input wire pbms_blk_src_t BLK_SRC,
	// Motor control inputs
	input wire logic START_DONE,
	input wire logic PROT_TRIP,
	// Results
	output logic [NELEM-1:0] ELEM_ACTIVE,
	output logic [1:0] MOTOR_STATE,
	output logic THERMAL_RESET,
	output logic IRQ
);

	// Products kept wide: a full-scale current times the percent scale overflows 20 bits
	function automatic logic above_start(input logic [IW-1:0] i, input logic [IW-1:0] flc);
		logic [IW+7:0] lhs;
		logic [IW+7:0] rhs;
		lhs = (IW+8)'(i) * (IW+8)'(START_PCT_DEN);
		rhs = (IW+8)'(flc) * (IW+8)'(START_PCT_NUM);
		above_start = lhs > rhs;
	endfunction

	// Strict compare: a current equal to the threshold still counts as running
	function automatic logic below_stop(input logic [IW-1:0] i, input logic [IW-1:0] th);
		below_stop = i < th;
	endfunction

	pbms_cfg_t cfg, next_cfg;
	logic [NEV-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, events;
	logic settings_wr;
	pbms_state_t state, next_state;
	logic [TMR_W-1:0] timer, next_timer;
	logic [CNT_W-1:0] start_cnt, next_cnt;
	logic restart_pend, next_pend;
	logic start_seen, stopped, prot_ok, next_irq;
	logic [NELEM-1:0] freq_blk, ext_blk, st_blk, rev_blk, next_active;
	logic [DW-1:0] next_rdata;

	// Register writes; settings writes restart the protection
	always_comb begin
		next_cfg = cfg;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		settings_wr = 1'b0;
		if (WR) begin
			case (ADDR)
				REG_CTRL: next_cfg.ctrl = WDATA[CTRL_W-1:0];
				REG_FUNC_EN: next_cfg.func_en = WDATA[NELEM-1:0];
				REG_EXT_PERMIT: next_cfg.permit = WDATA[NELEM-1:0];
				REG_FUND_SEL: next_cfg.fund_sel = WDATA[NELEM-1:0];
				REG_START_SEL: next_cfg.start_sel = WDATA[NELEM-1:0];
				REG_GROUND_SEL: next_cfg.ground_sel = WDATA[NELEM-1:0];
				REG_REV_PERMIT: next_cfg.rev_permit = WDATA[NELEM-1:0];
				REG_FLC: next_cfg.flc = WDATA[IW-1:0];
				REG_STOP_TH: next_cfg.stop_th = WDATA[IW-1:0];
				REG_IRQ_STAT: next_irq_stat = irq_stat & ~WDATA[NEV-1:0];
				REG_IRQ_MASK: next_irq_mask = WDATA[NEV-1:0];
				default: ;
			endcase
			// Any write that changes a setting counts, even with an equal value
			settings_wr = (ADDR <= REG_STOP_TH); // [RULE7]
		end
		// Set wins over a clear in the same cycle
		next_irq_stat = next_irq_stat | events;
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	// Read data valid only in the cycle after the strobe
	always_comb begin
		next_rdata = '0;
		if (RD) begin
			case (ADDR)
				REG_CTRL: next_rdata = DW'(cfg.ctrl);
				REG_FUNC_EN: next_rdata = DW'(cfg.func_en);
				REG_EXT_PERMIT: next_rdata = DW'(cfg.permit);
				REG_FUND_SEL: next_rdata = DW'(cfg.fund_sel);
				REG_START_SEL: next_rdata = DW'(cfg.start_sel);
				REG_GROUND_SEL: next_rdata = DW'(cfg.ground_sel);
				REG_REV_PERMIT: next_rdata = DW'(cfg.rev_permit);
				REG_FLC: next_rdata = DW'(cfg.flc);
				REG_STOP_TH: next_rdata = DW'(cfg.stop_th);
				REG_ACTIVE: next_rdata = DW'(ELEM_ACTIVE);
				REG_STATE: next_rdata = DW'(state);
				REG_START_CNT: next_rdata = DW'(start_cnt);
				REG_TIMER: next_rdata = DW'(timer);
				REG_IRQ_STAT: next_rdata = DW'(irq_stat);
				REG_IRQ_MASK: next_rdata = DW'(irq_mask);
				default: next_rdata = '0;
			endcase
		end
	end

	// Current thresholds
	always_comb begin
		start_seen = above_start(PHASE_I.a, cfg.flc) | above_start(PHASE_I.b, cfg.flc) |
			above_start(PHASE_I.c, cfg.flc); // [RULE16]
		stopped = below_stop(PHASE_I.a, cfg.stop_th) & below_stop(PHASE_I.b, cfg.stop_th) &
			below_stop(PHASE_I.c, cfg.stop_th); // [RULE17]
	end

	// Motor operation state machine
	always_comb begin
		next_state = state;
		next_timer = timer + 1'b1;
		next_cnt = start_cnt;
		next_pend = restart_pend;
		unique case (state)
			ST_STOP: begin
				// Pending flag lives one stop cycle: a running motor restarts uncounted
				next_pend = 1'b0;
				if (start_seen) begin
					next_state = ST_START; // [RULE12]
					if (!restart_pend) begin
						next_cnt = start_cnt + 1'b1; // [RULE9]
					end
				end
			end
			ST_START: begin
				if (PROT_TRIP) begin
					next_state = ST_TRIP; // [RULE13] [RULE14]
				end else if (stopped) begin
					next_state = ST_STOP; // [RULE13]
				end else if (START_DONE) begin
					next_state = ST_RUN; // [RULE12]
				end
			end
			ST_RUN: begin
				if (PROT_TRIP) begin
					next_state = ST_TRIP; // [RULE13] [RULE14]
				end else if (stopped) begin
					next_state = ST_STOP; // [RULE12]
				end
			end
			ST_TRIP: begin
				if (stopped) begin
					next_state = ST_STOP; // [RULE15]
				end
			end
		endcase
		if (next_state != state) begin
			next_timer = '0;
		end
		// Settings restart overrides everything, motor running or not
		if (settings_wr) begin
			next_state = ST_STOP; // [RULE8]
			next_timer = '0; // [RULE10]
			next_pend = 1'b1; // [RULE9]
			next_cnt = start_cnt;
		end
		events = '0;
		events[EV_START] = (next_state == ST_START) && (state != ST_START);
		events[EV_RUN] = (next_state == ST_RUN) && (state != ST_RUN);
		events[EV_STOP] = (next_state == ST_STOP) && (state != ST_STOP);
		events[EV_TRIP] = (next_state == ST_TRIP) && (state != ST_TRIP);
		events[EV_RESTART] = settings_wr;
	end

	// Enable and blocking gate per element
	always_comb begin
		prot_ok = cfg.ctrl[CTRL_PROT_ON] &
			~(cfg.ctrl[CTRL_PROT_PERMIT] & (BLK_SRC.prot_a | BLK_SRC.prot_b)); // [RULE1]
		freq_blk = (cfg.ctrl[CTRL_WIDE_FREQ] & ~FREQ_IN_RANGE) ? cfg.fund_sel : '0; // [RULE2]
		ext_blk = cfg.permit & (BLK_SRC.ext_a | BLK_SRC.ext_b); // [RULE4]
		st_blk = cfg.start_sel & {NELEM{BLK_SRC.start}}; // [RULE5]
		rev_blk = cfg.ground_sel & cfg.rev_permit & {NELEM{BLK_SRC.rev}}; // [RULE6]
		// Function enable gates last so no temporary input can revive an element
		next_active = {NELEM{prot_ok}} & ~freq_blk & ~ext_blk & ~st_blk & ~rev_blk &
			cfg.func_en; // [RULE1] [RULE3]
	end

	// State registers, all updated every edge
	always_ff @(posedge SYS_CLK or negedge NRST) begin // [RULE18]
		if (!NRST) begin
			cfg <= '{CTRL_RST, SEL_RST, SEL_RST, SEL_RST, SEL_RST, SEL_RST, SEL_RST, FLC_RST, STOP_TH_RST};
			irq_stat <= '0;
			irq_mask <= '0;
			state <= ST_STOP;
			timer <= '0;
			start_cnt <= '0;
			restart_pend <= 1'b0;
			ELEM_ACTIVE <= '0;
			THERMAL_RESET <= 1'b0;
			IRQ <= 1'b0;
			RDATA <= '0;
		end else begin
			cfg <= next_cfg;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			state <= next_state;
			timer <= next_timer;
			start_cnt <= next_cnt;
			restart_pend <= next_pend;
			ELEM_ACTIVE <= next_active;
			THERMAL_RESET <= settings_wr; // [RULE10]
			IRQ <= next_irq;
			RDATA <= next_rdata;
		end
	end

	// Four-state encoding straight from the state flops
	assign MOTOR_STATE = state; // [RULE11]

	// Checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	// Element gating, one check per enable or blocking condition
	a_global_gate: assert property (ELEM_ACTIVE != '0 |-> $past(prot_ok)) // [RULE1]
		else $error("element active without global protection");
	a_wide_freq: assert property ($past(cfg.ctrl[CTRL_WIDE_FREQ] && !FREQ_IN_RANGE) // [RULE2]
		|-> (ELEM_ACTIVE & $past(cfg.fund_sel)) == '0)
		else $error("fundamental element active off frequency");
	a_func_off: assert property ((ELEM_ACTIVE & ~$past(cfg.func_en)) == '0) // [RULE3]
		else $error("disabled element active");
	// Both sources checked apart, not through the gate's own blocking term
	a_ext_block: assert property ((ELEM_ACTIVE & $past(cfg.permit & BLK_SRC.ext_b)) == '0 && // [RULE4]
		(ELEM_ACTIVE & $past(cfg.permit & BLK_SRC.ext_a)) == '0)
		else $error("externally blocked element active");
	a_start_block: assert property ($past(BLK_SRC.start) // [RULE5]
		|-> (ELEM_ACTIVE & $past(cfg.start_sel)) == '0)
		else $error("start-blocked element active");
	a_rev_interl: assert property ($past(BLK_SRC.rev) // [RULE6]
		|-> (ELEM_ACTIVE & $past(cfg.ground_sel & cfg.rev_permit)) == '0)
		else $error("interlocked ground element active");

	// Restart; a write right behind the first one keeps the pulse up
	a_restart_stop: assert property (settings_wr |=> state == ST_STOP && timer == '0 // [RULE8]
		&& THERMAL_RESET ##1 !THERMAL_RESET || $past(settings_wr))
		else $error("restart did not force stop");
	a_thermal_pulse: assert property (THERMAL_RESET |-> $past(settings_wr)) // [RULE10]
		else $error("thermal reset without restart");
	a_no_recount: assert property (restart_pend && state == ST_STOP |=> $stable(start_cnt)) // [RULE9]
		else $error("start counted after restart");
	a_start_count: assert property (state == ST_STOP && !restart_pend && start_seen && !settings_wr // [RULE16]
		|=> state == ST_START && start_cnt == CNT_W'($past(start_cnt) + 1'b1))
		else $error("start not declared or counted");

	// Start and stop entered only on their current conditions or a restart
	a_start_entry: assert property (state == ST_START && $past(state) == ST_STOP // [RULE16]
		|-> $past(start_seen))
		else $error("start entered without current");
	a_stop_entry: assert property (state == ST_STOP && $past(state) != ST_STOP // [RULE17]
		|-> $past(stopped || settings_wr))
		else $error("stop entered with current flowing");
	a_trip_force: assert property (state inside {ST_START, ST_RUN} && PROT_TRIP && !settings_wr // [RULE14]
		|=> state == ST_TRIP)
		else $error("trip not forced");
	a_trip_exit: assert property (state == ST_TRIP && stopped && !settings_wr |=> state == ST_STOP) // [RULE15]
		else $error("trip did not end in stop");
	a_run_entry: assert property (state == ST_RUN |-> $past(state) inside {ST_START, ST_RUN}) // [RULE12]
		else $error("run entered illegally");
	a_trip_entry: assert property (state == ST_TRIP |-> $past(state) != ST_STOP) // [RULE13]
		else $error("trip entered from stop");

	// Register port and interrupt output
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == '0)
		else $error("read data outside its cycle");
	a_irq_level: assert property (IRQ == |(irq_stat & irq_mask))
		else $error("interrupt does not follow status");
	// Sticky events; a set beats a same-cycle write-one-to-clear
	a_set_wins: assert property (events != '0 |=> (irq_stat & $past(events)) == $past(events))
		else $error("event lost from status");

	// Main scenarios
	c_full_cycle: cover property (state == ST_STOP ##1 state == ST_START ##[1:8] state == ST_RUN);
	c_restart_run: cover property (state == ST_RUN && settings_wr ##1 state == ST_STOP ##1 state == ST_START);
	c_trip_stop: cover property (state == ST_TRIP ##[1:20] state == ST_STOP);
	c_start_abort: cover property (state == ST_START ##1 state == ST_STOP);
	c_irq: cover property (IRQ && WR && ADDR == REG_IRQ_STAT);

endmodule // pbms_core
`default_nettype wire

// file: hdl/pbms_pkg.sv
`default_nettype none
package pbms_pkg;
	// Sizes
	localparam int NELEM = 8;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int IW = 16;
	localparam int CNT_W = 16;
	localparam int TMR_W = 32;
	localparam int CTRL_W = 4;
	localparam int NEV = 5;
	// Register offsets
	localparam logic [AW-1:0] REG_CTRL = 8'h00;
	localparam logic [AW-1:0] REG_FUNC_EN = 8'h04;
	localparam logic [AW-1:0] REG_EXT_PERMIT = 8'h08;
	localparam logic [AW-1:0] REG_FUND_SEL = 8'h0C;
	localparam logic [AW-1:0] REG_START_SEL = 8'h10;
	localparam logic [AW-1:0] REG_GROUND_SEL = 8'h14;
	localparam logic [AW-1:0] REG_REV_PERMIT = 8'h18;
	localparam logic [AW-1:0] REG_FLC = 8'h1C;
	localparam logic [AW-1:0] REG_STOP_TH = 8'h20;
	localparam logic [AW-1:0] REG_ACTIVE = 8'h24;
	localparam logic [AW-1:0] REG_STATE = 8'h28;
	localparam logic [AW-1:0] REG_START_CNT = 8'h2C;
	localparam logic [AW-1:0] REG_TIMER = 8'h30;
	localparam logic [AW-1:0] REG_IRQ_STAT = 8'h34;
	localparam logic [AW-1:0] REG_IRQ_MASK = 8'h38;
	// Control bits
	localparam int CTRL_PROT_ON = 0;
	localparam int CTRL_PROT_PERMIT = 1;
	localparam int CTRL_WIDE_FREQ = 2;
	// Event bits
	localparam int EV_START = 0;
	localparam int EV_RUN = 1;
	localparam int EV_STOP = 2;
	localparam int EV_TRIP = 3;
	localparam int EV_RESTART = 4;
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
	localparam logic [NELEM-1:0] SEL_RST = 8'h00;
	localparam logic [IW-1:0] FLC_RST = 16'h0064;
	localparam logic [IW-1:0] STOP_TH_RST = 16'h000A;
	// Start threshold as a fraction of full load current
	localparam logic [IW+3:0] START_PCT_NUM = 20'h0_001E;
	localparam logic [IW+3:0] START_PCT_DEN = 20'h0_0064;
	// Types
	typedef struct packed {
		logic [IW-1:0] a;
		logic [IW-1:0] b;
		logic [IW-1:0] c;
	} pbms_phase_t;
	typedef struct packed {
		logic prot_a;
		logic prot_b;
		logic [NELEM-1:0] ext_a;
		logic [NELEM-1:0] ext_b;
		logic start;
		logic rev;
	} pbms_blk_src_t;
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [NELEM-1:0] func_en;
		logic [NELEM-1:0] permit;
		logic [NELEM-1:0] fund_sel;
		logic [NELEM-1:0] start_sel;
		logic [NELEM-1:0] ground_sel;
		logic [NELEM-1:0] rev_permit;
		logic [IW-1:0] flc;
		logic [IW-1:0] stop_th;
	} pbms_cfg_t;
	typedef enum logic [1:0] {ST_STOP, ST_START, ST_RUN, ST_TRIP} pbms_state_t;
endpackage
`default_nettype wire

// file: test/pbms_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t got %h want %h", $time, a, b); end end
module pbms_core_tb import pbms_pkg::*;;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [AW-1:0] addr = '0;
	logic [DW-1:0] wdata = '0;
	logic wr = 1'b0;
	logic rd_s = 1'b0;
	logic [DW-1:0] rdata;
	pbms_phase_t phase_i;
	logic freq_ok = 1'b1;
	pbms_blk_src_t blk = '0;
	logic start_done = 1'b0;
	logic trip = 1'b0;
	logic [NELEM-1:0] elem_active;
	logic [1:0] motor_state;
	logic thermal_reset;
	logic irq;
	logic [IW-1:0] lab = '0;
	logic [IW-1:0] lc = '0;
	logic [DW-1:0] d;
	int error_cnt = 0;
	int n_tests = 0;
	// 50 MHz clock
	always #10 clk = ~clk;
	pbms_core dut (.SYS_CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd_s),
		.RDATA(rdata), .PHASE_I(phase_i), .FREQ_IN_RANGE(freq_ok), .BLK_SRC(blk),
		.START_DONE(start_done), .PROT_TRIP(trip), .ELEM_ACTIVE(elem_active),
		.MOTOR_STATE(motor_state), .THERMAL_RESET(thermal_reset), .IRQ(irq));
	pbms_motor_model motor (.SYS_CLK(clk), .lvl_ab(lab), .lvl_c(lc), .phase_i(phase_i));
	// One-cycle write strobe
	task automatic wrr(input logic [AW-1:0] a, input logic [DW-1:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data is only valid in the cycle after the strobe
	task automatic rdr(input logic [AW-1:0] a, output logic [DW-1:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask
	// Three edges cover model lag plus the registered outputs
	task automatic ce(input logic [NELEM-1:0] e);
		repeat (3) @(posedge clk);
		#1 `CHK(elem_active, e)
	endtask
	task automatic cs(input logic [1:0] e);
		repeat (3) @(posedge clk);
		#1 `CHK(motor_state, e)
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Whole run needs well under 2000 cycles
	initial begin
		#(20 * 5000);
		error_cnt++;
		$display("BAD %0t watchdog expired", $time);
		give_verdict;
	end
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1 `CHK(motor_state, ST_STOP)
		rdr(REG_CTRL, d);
		`CHK(d, 32'h0000_0000)
		rdr(REG_FLC, d);
		`CHK(d, 32'h0000_0064)
		rdr(REG_STOP_TH, d);
		`CHK(d, 32'h0000_000A)
		rdr(8'h3C, d);
		`CHK(d, 32'h0000_0000)
		$display("test reset done");
		// Enable chain, one condition at a time
		ce(8'h00);
		wrr(REG_FUNC_EN, 32'h0000_00FF);
		ce(8'h00);
		wrr(REG_CTRL, 32'h0000_0003);
		ce(8'hFF);
		blk.prot_b <= 1'b1;
		ce(8'h00);
		// Without the permit bit the global block source is ignored
		wrr(REG_CTRL, 32'h0000_0001);
		ce(8'hFF);
		blk.prot_b <= 1'b0;
		wrr(REG_FUNC_EN, 32'h0000_000F);
		blk.ext_a <= 8'hFF;
		ce(8'h0F);
		wrr(REG_EXT_PERMIT, 32'h0000_00F3);
		ce(8'h0C);
		blk.ext_a <= 8'h00;
		blk.ext_b <= 8'h02;
		ce(8'h0D);
		blk.ext_b <= 8'h00;
		wrr(REG_FUND_SEL, 32'h0000_0005);
		freq_ok <= 1'b0;
		ce(8'h0F);
		wrr(REG_CTRL, 32'h0000_0007);
		ce(8'h0A);
		freq_ok <= 1'b1;
		wrr(REG_START_SEL, 32'h0000_0008);
		blk.start <= 1'b1;
		ce(8'h07);
		blk.start <= 1'b0;
		wrr(REG_GROUND_SEL, 32'h0000_0004);
		blk.rev <= 1'b1;
		ce(8'h0F);
		wrr(REG_REV_PERMIT, 32'h0000_0004);
		ce(8'h0B);
		rdr(REG_ACTIVE, d);
		`CHK(d, 32'h0000_000B)
		blk.rev <= 1'b0;
		$display("test elements done");
		// Motor cycle, restart and trips
		wrr(REG_IRQ_STAT, 32'h0000_001F);
		wrr(REG_IRQ_MASK, 32'h0000_0008);
		lab <= 16'h001E;
		cs(ST_STOP);
		`CHK(irq, 1'b0)
		lab <= 16'h001F;
		cs(ST_START);
		start_done <= 1'b1;
		cs(ST_RUN);
		rdr(REG_START_CNT, d);
		`CHK(d, 32'h0000_0001)
		start_done <= 1'b0;
		wrr(REG_STOP_TH, 32'h0000_000A);
		#1 `CHK(motor_state, ST_STOP)
		`CHK(thermal_reset, 1'b1)
		cs(ST_START);
		`CHK(thermal_reset, 1'b0)
		// Timer cleared on entry to start, then three cycles counted before the read
		rdr(REG_TIMER, d);
		`CHK(d, 32'h0000_0003)
		start_done <= 1'b1;
		cs(ST_RUN);
		rdr(REG_START_CNT, d);
		`CHK(d, 32'h0000_0001)
		start_done <= 1'b0;
		trip <= 1'b1;
		cs(ST_TRIP);
		`CHK(irq, 1'b1)
		trip <= 1'b0;
		wrr(REG_IRQ_STAT, 32'h0000_0008);
		lab <= 16'h0005;
		lc <= 16'h000A;
		cs(ST_TRIP);
		`CHK(irq, 1'b0)
		lc <= 16'h0009;
		cs(ST_STOP);
		lab <= 16'h001F;
		cs(ST_START);
		lab <= 16'h0000;
		lc <= 16'h0000;
		cs(ST_STOP);
		lab <= 16'h001F;
		cs(ST_START);
		trip <= 1'b1;
		cs(ST_TRIP);
		trip <= 1'b0;
		lab <= 16'h0000;
		cs(ST_STOP);
		rdr(REG_STATE, d);
		`CHK(d, 32'h0000_0000)
		rdr(REG_START_CNT, d);
		`CHK(d, 32'h0000_0003)
		$display("test motor done");
		give_verdict;
	end
endmodule // pbms_core_tb
`default_nettype wire

// file: test/pbms_motor_model.sv
`timescale 1ns/10ps
`default_nettype none
// Motor load seen by the relay: phases a and b share one level, c has its own
module pbms_motor_model import pbms_pkg::*; (
	// Clock
	input wire logic SYS_CLK,
	// Load levels
	input wire logic [IW-1:0] lvl_ab,
	input wire logic [IW-1:0] lvl_c,
	// Phase currents
	output pbms_phase_t phase_i
);
	// Registered like a sampled meter, so currents lag a command by one edge
	always_ff @(posedge SYS_CLK) begin
		phase_i <= '{a: lvl_ab, b: lvl_ab, c: lvl_c};
	end
endmodule // pbms_motor_model
`default_nettype wire
